//--- verilog/uart_cfg_params.svh
// Offsets, field positions, reset values and timing counts of the block.
// What this block does
// (R01) Writing one resets channel; bit self-clears
// (R02) Soft reset restores channel register defaults
// (R03) Bit n of reset register is channel n
// (R04) Sleep bit per channel; cleared at reset
// (R05) Channel sleeps only with no interrupt pending
// (R06) All eight asleep stops the oscillator
// (R07) Received byte or modem change wakes device
// (R08) Channel usable only after 32 clock warm-up
// (R09) Wake-up raises interrupt showing nothing pending
// (R10) Wake interrupt reported with source code zero
// (R11) Read-only device type code register
// (R12) Read-only silicon revision, counting from one
// (R13) Broadcast bit writes all eight channels
// (R14) Four address lines select sixteen channel locations
// (R15) Offset zero: holding registers or divisor low
// (R16) Divisor high and fraction, else interrupt enable
// (R17) Offset two: interrupt status read, fifo write
// (R18) Line control, modem control, read-only line status
// (R19) Offset six: modem status read, turnaround write
// (R20) Offset seven is a plain scratch byte
// (R21) Feature registers at eight, nine; ten, eleven reserved
// (R22) Offset twelve: stop char write, flags read
// (R23) Offsets 13-15 write-only characters, reads reserved
// (R24) Broadcast reads still return one addressed channel
`ifndef UART_CFG_PARAMS_SVH
`define UART_CFG_PARAMS_SVH

// ---------------------------------------------------------------------
// Device-wide register offsets, reached with the global select high.
// ---------------------------------------------------------------------
`define GREG_SOFT_RESET 4'h0
`define GREG_SLEEP 4'h1
`define GREG_TYPE_CODE 4'h2
`define GREG_REVISION 4'h3
`define GREG_BCAST 4'h4

// ---------------------------------------------------------------------
// Channel register offsets on the four channel address lines.
// ---------------------------------------------------------------------
`define CREG_HOLD 4'h0
`define CREG_DIV_HI_IEN 4'h1
`define CREG_INT_STATUS_FIFO_CONTROL 4'h2
`define CREG_LINE_CTL 4'h3
`define CREG_MODEM_CTL 4'h4
`define CREG_LINE_STAT 4'h5
`define CREG_MSR_DLY 4'h6
`define CREG_SCRATCH 4'h7
`define CREG_FEAT_CTL 4'h8
`define CREG_ENH_FUNC 4'h9
`define CREG_RSVD_A 4'hA
`define CREG_RSVD_B 4'hB
`define CREG_STOP1 4'hC
`define CREG_STOP2 4'hD
`define CREG_RESUME1 4'hE
`define CREG_RESUME2 4'hF

// ---------------------------------------------------------------------
// Fields, reset values, identity values and timing.
// ---------------------------------------------------------------------
`define BCAST_BIT 0
`define GREG_RESET_VALUE 8'h00
`define RSVD_READ_VALUE 8'h00
// Arbitrary identity values, not those of any real part.
`define DEVICE_TYPE_CODE 8'hA5
`define SILICON_REVISION 8'h03
// Interrupt source code for nothing pending, shared by wake-up.
`define WAKE_ISR_CODE 4'h0
// Warm-up length in crystal clocks and its counter width.
`define WAKE_CLOCKS 32
`define WAKE_CYCLES 6'd32
`define WAKE_CNT_W 6

`endif

//--- verilog/uart_cfg_pkg.sv
// Types shared by the octal UART global configuration block.
package uart_cfg_pkg;

  // -------------------------------------------------------------------
  // Power states of the whole device.
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_OSC_OFF,
    PWR_WARMUP
  } power_t;

  // -------------------------------------------------------------------
  // Decoded channel register handed to the eight channels.
  // -------------------------------------------------------------------
  typedef enum logic [4:0] {
    CH_NONE,
    CH_RX_HOLD,
    CH_TX_HOLD,
    CH_DIV_LOW,
    CH_DIV_HIGH,
    CH_DIV_FRAC,
    CH_INT_ENABLE,
    CH_INT_STATUS,
    CH_FIFO_CTL,
    CH_LINE_CTL,
    CH_MODEM_CTL,
    CH_LINE_STAT,
    CH_MODEM_STAT,
    CH_TURN_DELAY,
    CH_SCRATCH,
    CH_FEAT_CTL,
    CH_ENH_FUNC,
    CH_STOP1,
    CH_FLOW_FLAGS,
    CH_STOP2,
    CH_RESUME1,
    CH_RESUME2
  } chan_reg_t;

  // -------------------------------------------------------------------
  // Entire state of the block, registered as one word.
  // -------------------------------------------------------------------
  typedef struct packed {
    power_t pwr;
    logic [5:0] warm_cnt;
    logic [7:0] soft_rst;
    logic [7:0] sleep_en;
    logic bcast;
    logic wake_flag;
    logic [7:0] ch_wr;
    logic [7:0] ch_rd;
    chan_reg_t ch_reg;
    logic [7:0] ch_wdata;
    logic rd_pend;
    logic [2:0] rd_chan;
    logic [7:0] rdata;
    logic rd_done;
  } core_state_t;

endpackage : uart_cfg_pkg

//--- verilog/octal_uart_global_config_decode.sv
// Global configuration registers and channel register decode.
`timescale 1ns/1ns
`include "uart_cfg_params.svh"

module octal_uart_global_config_decode
  import uart_cfg_pkg::*;
(
  input wire logic core_clk_i, // Crystal clock, 50 MHz.
  input wire logic rst_b_i, // Hardware reset, active low.
  input wire logic cs_i, // Bus access in this cycle.
  input wire logic glob_i, // Access targets device-wide registers.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  input wire logic [2:0] chan_i, // Channel number.
  input wire logic [3:0] addr_i, // Register address lines.
  input wire logic [7:0] wdata_i, // Write data.
  output logic [7:0] rdata_o, // Read data, held until next read.
  output logic rd_done_o, // Pulse: rdata_o has been updated.
  input wire logic [7:0] ch_div_en_i, // Divisor enable bit per channel.
  input wire logic [63:0] ch_rdata_i, // Read data, byte n is channel n.
  input wire logic [7:0] ch_int_pend_i, // Channel interrupt pending.
  input wire logic [7:0] ch_rx_byte_i, // Channel received a byte.
  input wire logic [7:0] ch_modem_chg_i, // Channel modem input changed.
  output logic [7:0] ch_wr_o, // Pulse: write to decoded register.
  output logic [7:0] ch_rd_o, // Pulse: read of decoded register.
  output chan_reg_t ch_reg_o, // Decoded register of the access.
  output logic [7:0] ch_wdata_o, // Write data to channels.
  output logic [7:0] ch_soft_rst_o, // Pulse: reset channel to defaults.
  output logic [7:0] ch_asleep_o, // Channel is in sleep mode.
  output logic [7:0] ch_ready_o, // Channel fully functional.
  output logic osc_en_o, // On-chip oscillator runs.
  output logic wake_int_o, // Wake-up interrupt pending.
  output logic [3:0] wake_isr_code_o // Source code of wake interrupt.
);

  // -------------------------------------------------------------------
  // State and combinational helpers.
  // -------------------------------------------------------------------
  core_state_t st; // Registered state.
  core_state_t next_st; // Next state.
  logic [7:0] asleep; // Channels actually sleeping now.
  logic wake_ev; // Any wake source seen.
  logic host_wr; // Host write this cycle.
  logic host_rd; // Host read this cycle.
  logic isr_read; // Host reads an interrupt status.
  chan_reg_t dec_reg; // Decode of the present address.
  logic [7:0] sel_data [8]; // Channel read data as bytes.

  // Split the flat channel read bus into bytes, one per channel.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_chan
      assign sel_data[gi] = ch_rdata_i[gi*8 +: 8];
    end
  endgenerate

  // -------------------------------------------------------------------
  // Channel register decode.
  // -------------------------------------------------------------------
  // Maps the four address lines, the divisor enable bit and the
  // direction onto one register. Reserved reads map to none so the
  // block answers them with zero itself.
  function automatic chan_reg_t decode(input logic [3:0] a,
                                       input logic dl,
                                       input logic wr);
    chan_reg_t r;
    r = CH_NONE;
    case (a) // R14
      `CREG_HOLD: begin // R15
        if (dl) begin
          r = CH_DIV_LOW;
        end else begin
          r = wr ? CH_TX_HOLD : CH_RX_HOLD;
        end
      end
      `CREG_DIV_HI_IEN: begin // R16
        r = dl ? CH_DIV_HIGH : CH_INT_ENABLE;
      end
      `CREG_INT_STATUS_FIFO_CONTROL: begin
        if (dl) begin
          r = CH_DIV_FRAC; // R16
        end else begin
          r = wr ? CH_FIFO_CTL : CH_INT_STATUS; // R17
        end
      end
      `CREG_LINE_CTL: r = CH_LINE_CTL; // R18
      `CREG_MODEM_CTL: r = CH_MODEM_CTL; // R18
      `CREG_LINE_STAT: r = wr ? CH_NONE : CH_LINE_STAT; // R18
      `CREG_MSR_DLY: r = wr ? CH_TURN_DELAY : CH_MODEM_STAT; // R19
      `CREG_SCRATCH: r = CH_SCRATCH; // R20
      `CREG_FEAT_CTL: r = CH_FEAT_CTL; // R21
      `CREG_ENH_FUNC: r = CH_ENH_FUNC; // R21
      `CREG_STOP1: r = wr ? CH_STOP1 : CH_FLOW_FLAGS; // R22
      `CREG_STOP2: r = wr ? CH_STOP2 : CH_NONE; // R23
      `CREG_RESUME1: r = wr ? CH_RESUME1 : CH_NONE; // R23
      `CREG_RESUME2: r = wr ? CH_RESUME2 : CH_NONE; // R23
      default: r = CH_NONE; // R21
    endcase
    return r;
  endfunction : decode

  // -------------------------------------------------------------------
  // Sleep qualification.
  // -------------------------------------------------------------------
  // A pending wake interrupt counts as pending, so the device cannot
  // fall straight back asleep before the host has seen the wake-up.
  always_comb begin
    asleep = st.sleep_en & ~ch_int_pend_i & {8{~st.wake_flag}}; // R05
    wake_ev = |(ch_rx_byte_i | ch_modem_chg_i); // R07
    host_wr = cs_i & wr_i;
    host_rd = cs_i & rd_i & ~wr_i;
    isr_read = host_rd & ~glob_i & (addr_i == `CREG_INT_STATUS_FIFO_CONTROL)
               & ~ch_div_en_i[chan_i];
    dec_reg = decode(addr_i, ch_div_en_i[chan_i], wr_i);
  end

  // -------------------------------------------------------------------
  // Next-state logic.
  // -------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.soft_rst = 8'h00; // R01
    next_st.ch_wr = 8'h00;
    next_st.ch_rd = 8'h00;
    next_st.rd_pend = 1'b0;
    next_st.rd_done = 1'b0;
    next_st.ch_reg = CH_NONE;

    // Device-wide register writes.
    if (host_wr && glob_i) begin
      case (addr_i)
        `GREG_SOFT_RESET: next_st.soft_rst = wdata_i; // R03
        `GREG_SLEEP: next_st.sleep_en = wdata_i; // R04
        `GREG_BCAST: next_st.bcast = wdata_i[`BCAST_BIT]; // R13
        default: begin
          // Identity registers are read-only; writes are dropped.
        end
      endcase
    end

    // Channel writes, fanned out to all channels when broadcasting.
    if (host_wr && !glob_i && dec_reg != CH_NONE) begin
      if (st.bcast) begin
        next_st.ch_wr = 8'hFF; // R13
      end else begin
        next_st.ch_wr = 8'h01 << chan_i;
      end
      next_st.ch_reg = dec_reg;
      next_st.ch_wdata = wdata_i;
    end

    // Reads: device-wide and reserved ones answer next edge, other channel
    // ones a cycle later once the channel has presented its byte.
    if (host_rd && glob_i) begin
      next_st.rd_done = 1'b1;
      case (addr_i)
        `GREG_SOFT_RESET: next_st.rdata = `GREG_RESET_VALUE; // R01
        `GREG_SLEEP: next_st.rdata = st.sleep_en;
        `GREG_TYPE_CODE: next_st.rdata = `DEVICE_TYPE_CODE; // R11
        `GREG_REVISION: next_st.rdata = `SILICON_REVISION; // R12
        `GREG_BCAST: next_st.rdata = {7'h00, st.bcast};
        default: next_st.rdata = `RSVD_READ_VALUE;
      endcase
    end else if (host_rd && dec_reg == CH_NONE) begin
      next_st.rd_done = 1'b1;
      next_st.rdata = `RSVD_READ_VALUE; // R23
    end else if (host_rd) begin
      next_st.ch_rd = 8'h01 << chan_i; // R24
      next_st.ch_reg = dec_reg;
      next_st.rd_pend = 1'b1;
      next_st.rd_chan = chan_i;
    end
    if (st.rd_pend) begin
      next_st.rdata = sel_data[st.rd_chan]; // R24
      next_st.rd_done = 1'b1;
    end

    // Power sequencing.
    case (st.pwr)
      PWR_RUN: begin
        if (&asleep) begin
          next_st.pwr = PWR_OSC_OFF; // R06
        end
      end
      PWR_OSC_OFF: begin
        if (wake_ev) begin
          next_st.pwr = PWR_WARMUP; // R07
          next_st.warm_cnt = '0;
        end
      end
      PWR_WARMUP: begin
        next_st.warm_cnt = st.warm_cnt + 6'd1;
        if (st.warm_cnt == `WAKE_CYCLES - 6'd1) begin
          next_st.pwr = PWR_RUN; // R08
        end
      end
      default: next_st.pwr = PWR_RUN;
    endcase

    // Wake flag: set wins over the clear by a status read.
    if (isr_read) begin
      next_st.wake_flag = 1'b0;
    end
    if (st.pwr == PWR_OSC_OFF && wake_ev) begin
      next_st.wake_flag = 1'b1; // R09
    end
  end

  // -------------------------------------------------------------------
  // State register.
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0; // R04
      st.pwr <= PWR_RUN;
      st.ch_reg <= CH_NONE;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------
  // Outputs.
  // -------------------------------------------------------------------
  // Channels are held out of service while the oscillator is off or
  // still settling; a sleeping channel is likewise not ready.
  always_comb begin
    rdata_o = st.rdata;
    rd_done_o = st.rd_done;
    ch_wr_o = st.ch_wr;
    ch_rd_o = st.ch_rd;
    ch_reg_o = st.ch_reg;
    ch_wdata_o = st.ch_wdata;
    ch_soft_rst_o = st.soft_rst; // R02
    ch_asleep_o = (st.pwr == PWR_RUN) ? asleep : 8'hFF;
    ch_ready_o = (st.pwr == PWR_RUN) ? ~asleep : 8'h00; // R08
    osc_en_o = (st.pwr != PWR_OSC_OFF); // R06
    wake_int_o = st.wake_flag; // R09
    wake_isr_code_o = `WAKE_ISR_CODE; // R10
  end

  // -------------------------------------------------------------------
  // Assertions and covers.
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Counts cycles spent in warm-up, for the duration check.
  logic [6:0] warm_seen;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      warm_seen <= 7'h00;
    end else if (st.pwr == PWR_WARMUP) begin
      warm_seen <= warm_seen + 7'd1;
    end else begin
      warm_seen <= 7'h00;
    end
  end

  a_rst_self_clear: assert property ( // R01
    host_wr && glob_i && addr_i == `GREG_SOFT_RESET |=>
      ch_soft_rst_o == $past(wdata_i) ##1 ch_soft_rst_o == 8'h00)
    else $error("soft reset pulse wrong");
  a_sleep_needs_idle: assert property ( // R05
    (ch_asleep_o & ch_int_pend_i) == 8'h00 || !osc_en_o
    || st.pwr != PWR_RUN)
    else $error("channel asleep with interrupt pending");
  a_osc_stop_all: assert property ( // R06
    st.pwr == PWR_RUN && &asleep |=> !osc_en_o)
    else $error("oscillator not stopped");
  a_wake_start: assert property ( // R07
    !osc_en_o && wake_ev |=> osc_en_o && wake_int_o)
    else $error("no wake-up on event");
  a_warmup_len: assert property ( // R08
    st.pwr == PWR_WARMUP |-> ch_ready_o == 8'h00 && warm_seen < 7'd32)
    else $error("warm-up too long or channel ready early");
  a_wake_code: assert property ( // R10
    wake_int_o |-> wake_isr_code_o == 4'h0)
    else $error("wake code not zero");
  a_ident_read: assert property ( // R11
    host_rd && glob_i && addr_i == `GREG_TYPE_CODE |=>
      rd_done_o && rdata_o == `DEVICE_TYPE_CODE)
    else $error("type code read wrong");
  a_bcast_write: assert property ( // R13
    host_wr && !glob_i && st.bcast && addr_i == `CREG_SCRATCH |=>
      ch_wr_o == 8'hFF && ch_reg_o == CH_SCRATCH)
    else $error("broadcast write not fanned out");
  a_read_one_chan: assert property ( // R24
    host_rd && !glob_i && addr_i == `CREG_LINE_STAT |=>
      $onehot(ch_rd_o) ##1 rd_done_o)
    else $error("read not single channel");
  a_rsvd_zero: assert property ( // R21
    host_rd && !glob_i && addr_i == `CREG_RSVD_A |=>
      rd_done_o && rdata_o == 8'h00 && ch_rd_o == 8'h00)
    else $error("reserved read not zero");

  c_full_sleep: cover property (st.pwr == PWR_OSC_OFF);
  c_wake_done: cover property (st.pwr == PWR_WARMUP ##1 st.pwr == PWR_RUN);
  c_bcast: cover property (ch_wr_o == 8'hFF);
  c_div_read: cover property (ch_rd_o != 8'h00 && ch_reg_o == CH_DIV_LOW);

endmodule : octal_uart_global_config_decode

//--- verif/chan_array_model.sv
// Stand-in for the eight channel register sets answering channel reads.
`timescale 1ns/1ns

module chan_array_model
  import uart_cfg_pkg::*;
(
  input wire logic core_clk_i, // Crystal clock.
  input wire logic rst_b_i, // Hardware reset, active low.
  input wire logic [7:0] rd_strobe_i, // Read pulse per channel.
  input wire chan_reg_t reg_i, // Decoded register of the read.
  output logic [63:0] rdata_o // Byte n is channel n.
);

  // Changing filler, so that a byte nobody reads never looks stale.
  logic [7:0] noise;

  // The filler moves every cycle, like a bus whose driver has let go.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      noise <= 8'h5A;
    end else begin
      noise <= noise + 8'h3B;
    end
  end

  // A read channel returns its number over the register code.
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      rdata_o[n*8 +: 8] = rd_strobe_i[n] ? {3'(n), 5'(reg_i)} : noise ^ 8'(n);
    end
  end

endmodule : chan_array_model

//--- verif/octal_uart_global_config_decode_test.sv
// Self-checking bench of the global configuration and decode block.
`timescale 1ns/1ns
`include "uart_cfg_params.svh"

module octal_uart_global_config_decode_test
  import uart_cfg_pkg::*;
;
  // -------------------------------------------------------------------
  // Stimulus, observed outputs and scratch values.
  // -------------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cs_i = 1'b0;
  logic glob_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] chan_i = 3'h0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] ch_div_en_i = 8'h00;
  logic [7:0] ch_int_pend_i = 8'hFF;
  logic [7:0] ch_rx_byte_i = 8'h00;
  logic [7:0] ch_modem_chg_i = 8'h00;
  logic [63:0] ch_rdata_i;
  logic [7:0] rdata_o;
  logic rd_done_o;
  logic [7:0] ch_wr_o;
  logic [7:0] ch_rd_o;
  chan_reg_t ch_reg_o;
  logic [7:0] ch_wdata_o;
  logic [7:0] ch_soft_rst_o;
  logic [7:0] ch_asleep_o;
  logic [7:0] ch_ready_o;
  logic osc_en_o;
  logic wake_int_o;
  logic [3:0] wake_isr_code_o;
  int bad_count = 0;
  int checked = 0;
  int n;
  logic [2:0] c;
  logic [3:0] a;
  logic [7:0] d;
  logic [7:0] dv;
  chan_reg_t e;
  chan_reg_t rd_reg;
  logic [7:0] wr_strb;
  logic [7:0] rd_strb;
  logic [7:0] rst_seen;
  logic [7:0] rd_val;

  octal_uart_global_config_decode i_dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cs_i(cs_i),
    .glob_i(glob_i), .wr_i(wr_i), .rd_i(rd_i), .chan_i(chan_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rd_done_o(rd_done_o), .ch_div_en_i(ch_div_en_i),
    .ch_rdata_i(ch_rdata_i), .ch_int_pend_i(ch_int_pend_i),
    .ch_rx_byte_i(ch_rx_byte_i), .ch_modem_chg_i(ch_modem_chg_i),
    .ch_wr_o(ch_wr_o), .ch_rd_o(ch_rd_o), .ch_reg_o(ch_reg_o),
    .ch_wdata_o(ch_wdata_o), .ch_soft_rst_o(ch_soft_rst_o),
    .ch_asleep_o(ch_asleep_o), .ch_ready_o(ch_ready_o),
    .osc_en_o(osc_en_o), .wake_int_o(wake_int_o),
    .wake_isr_code_o(wake_isr_code_o));

  chan_array_model i_chans (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .rd_strobe_i(ch_rd_o),
    .reg_i(ch_reg_o), .rdata_o(ch_rdata_i));

  // Free-running 50 MHz crystal clock.
  always begin
    #10;
    core_clk_i = ~core_clk_i;
  end

  // -------------------------------------------------------------------
  // Compares, bus cycles and expectations.
  // -------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_reg(input chan_reg_t got, input chan_reg_t exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  // One access held for one edge; strobes are captured just after it.
  task automatic bus(input logic g, input logic w, input logic [2:0] ch,
                     input logic [3:0] ad, input logic [7:0] dat);
    @(posedge core_clk_i);
    cs_i <= 1'b1;
    glob_i <= g;
    wr_i <= w;
    rd_i <= ~w;
    chan_i <= ch;
    addr_i <= ad;
    wdata_i <= dat;
    @(posedge core_clk_i);
    cs_i <= 1'b0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
    wr_strb = ch_wr_o;
    rd_strb = ch_rd_o;
    rd_reg = ch_reg_o;
    rst_seen = ch_soft_rst_o;
  endtask : bus

  // A read waits a bounded time for its completion pulse.
  task automatic rd(input logic g, input logic [2:0] ch, input logic [3:0] ad);
    int i;
    bus(g, 1'b0, ch, ad, 8'h00);
    for (i = 0; i < 4 && rd_done_o !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (i == 4) begin
      bad_count++;
      results();
    end
    rd_val = rdata_o;
  endtask : rd

  // Register a channel access should reach, or none if it is dropped.
  function automatic chan_reg_t exp_reg(input logic [3:0] ad, input logic dl,
                                        input logic w);
    case (ad)
      4'h0: return dl ? CH_DIV_LOW : (w ? CH_TX_HOLD : CH_RX_HOLD);
      4'h1: return dl ? CH_DIV_HIGH : CH_INT_ENABLE;
      4'h2: return dl ? CH_DIV_FRAC : (w ? CH_FIFO_CTL : CH_INT_STATUS);
      4'h3: return CH_LINE_CTL;
      4'h4: return CH_MODEM_CTL;
      4'h5: return w ? CH_NONE : CH_LINE_STAT;
      4'h6: return w ? CH_TURN_DELAY : CH_MODEM_STAT;
      4'h7: return CH_SCRATCH;
      4'h8: return CH_FEAT_CTL;
      4'h9: return CH_ENH_FUNC;
      4'hC: return w ? CH_STOP1 : CH_FLOW_FLAGS;
      4'hD: return w ? CH_STOP2 : CH_NONE;
      4'hE: return w ? CH_RESUME1 : CH_NONE;
      4'hF: return w ? CH_RESUME2 : CH_NONE;
      default: return CH_NONE;
    endcase
  endfunction : exp_reg

  task automatic results();
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // -------------------------------------------------------------------
  // Main sequence.
  // -------------------------------------------------------------------
  initial begin
    void'($urandom(99));
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk8(ch_ready_o, 8'hFF);
    rd(1'b1, 3'h0, `GREG_SLEEP);
    chk8(rd_val, `GREG_RESET_VALUE);
    rd(1'b1, 3'h0, `GREG_BCAST);
    chk8(rd_val, `GREG_RESET_VALUE);
    // Identity registers must ignore a write attempt.
    bus(1'b1, 1'b1, 3'h0, `GREG_TYPE_CODE, 8'h00);
    rd(1'b1, 3'h0, `GREG_TYPE_CODE);
    chk8(rd_val, `DEVICE_TYPE_CODE);
    bus(1'b1, 1'b1, 3'h0, `GREG_REVISION, 8'hFF);
    rd(1'b1, 3'h0, `GREG_REVISION);
    chk8(rd_val, `SILICON_REVISION);
    // Soft reset: lowest and highest channel first, then random masks.
    for (int k = 0; k < 5; k++) begin
      d = (k == 0) ? 8'h01 : (k == 1) ? 8'h80 : 8'($urandom);
      bus(1'b1, 1'b1, 3'($urandom), `GREG_SOFT_RESET, d);
      chk8(rst_seen, d);
      @(posedge core_clk_i);
      #1;
      chk8(ch_soft_rst_o, 8'h00);
      rd(1'b1, 3'h0, `GREG_SOFT_RESET);
      chk8(rd_val, 8'h00);
    end
    // Sleep bits read back; a pending channel never reports asleep.
    d = 8'($urandom);
    ch_int_pend_i <= 8'($urandom) | 8'h01;
    bus(1'b1, 1'b1, 3'h0, `GREG_SLEEP, d);
    rd(1'b1, 3'h0, `GREG_SLEEP);
    chk8(rd_val, d);
    chk8(ch_asleep_o, d & ~ch_int_pend_i);
    bus(1'b1, 1'b1, 3'h0, `GREG_SLEEP, 8'h00);
    // Every offset read and written, divisor bit random, then broadcast.
    for (int k = 0; k < 64; k++) begin
      if (k[4:0] == 5'h00) begin
        bus(1'b1, 1'b1, 3'h0, `GREG_BCAST, {7'h00, k[5]});
      end
      c = 3'($urandom);
      dv = 8'($urandom);
      a = k[3:0];
      ch_div_en_i <= dv;
      e = exp_reg(a, dv[c], k[4]);
      if (k[4]) begin
        d = 8'($urandom);
        bus(1'b0, 1'b1, c, a, d);
        chk_reg(rd_reg, e);
        chk8(wr_strb, e == CH_NONE ? 8'h00 : k[5] ? 8'hFF : 8'h01 << c);
        if (e != CH_NONE) chk8(ch_wdata_o, d);
      end else begin
        rd(1'b0, c, a);
        chk_reg(rd_reg, e);
        chk8(rd_strb, e == CH_NONE ? 8'h00 : 8'h01 << c);
        chk8(rd_val, e == CH_NONE ? `RSVD_READ_VALUE : {c, 5'(e)});
      end
    end
    bus(1'b1, 1'b1, 3'h0, `GREG_BCAST, 8'h00);
    // Full sleep, oscillator stop, wake by data then by a modem change.
    for (int k = 0; k < 2; k++) begin
      ch_int_pend_i <= 8'h01;
      bus(1'b1, 1'b1, 3'h0, `GREG_SLEEP, 8'hFF);
      @(posedge core_clk_i);
      #1;
      chk8(ch_asleep_o, 8'hFE);
      chk8({7'h00, osc_en_o}, 8'h01);
      ch_int_pend_i <= 8'h00;
      @(posedge core_clk_i);
      #1;
      chk8({7'h00, osc_en_o}, 8'h00);
      chk8(ch_asleep_o, 8'hFF);
      d = 8'h01 << 3'($urandom);
      if (k == 0) ch_rx_byte_i <= d;
      else ch_modem_chg_i <= d;
      @(posedge core_clk_i);
      #1;
      ch_rx_byte_i <= 8'h00;
      ch_modem_chg_i <= 8'h00;
      chk8({7'h00, osc_en_o}, 8'h01);
      chk8({7'h00, wake_int_o}, 8'h01);
      chk8({4'h0, wake_isr_code_o}, {4'h0, `WAKE_ISR_CODE});
      for (n = 0; n < 40 && ch_ready_o === 8'h00; n++) begin
        @(posedge core_clk_i);
        #1;
      end
      chk8(8'(n), 8'(`WAKE_CLOCKS));
      chk8(ch_ready_o, 8'hFF);
      bus(1'b1, 1'b1, 3'h0, `GREG_SLEEP, 8'h00);
      ch_div_en_i <= 8'h00;
      rd(1'b0, 3'(k), `CREG_INT_STATUS_FIFO_CONTROL);
      chk8({7'h00, wake_int_o}, 8'h00);
    end
    results();
  end

endmodule : octal_uart_global_config_decode_test
